// [design/dsp_rst_pkg.sv]
// Constants and types shared by the reset sequencer and its register slave
package dsp_rst_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CPU_PERIOD_PS = 5000;
	localparam int SYNC_STAGES = 2;
	localparam int ASSERT_MIN_E = 2;
	localparam int RELEASE_MIN_E = 16;
	localparam int RELEASE_MIN_P = 2;
	localparam int RELEASE_MAX_P = 16070;
	localparam int RELEASE_MIN_CYC = (RELEASE_MIN_P * CPU_PERIOD_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int RELEASE_MAX_CYC = (RELEASE_MAX_P * CPU_PERIOD_PS) / CLK_PERIOD_PS;
	localparam int CPU_DIV_FOUR = 4;
	localparam int CPU_DIV_SIX = 6;

	// ==========================================================
	// Strap layout
	localparam int STRAP_W = 13;
	localparam int STRAP_HOST_D5_BIT = 0;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [31:0] CTRL_OFF = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFF = 32'h0000_0004;
	localparam logic [31:0] STRAPS_OFF = 32'h0000_0008;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SYNCED_BIT = 2;
	localparam int STAT_CORE_BIT = 3;
	localparam int STAT_EEPROM_BIT = 4;
	localparam int STAT_PLL_BIT = 5;

	// ==========================================================
	// Modes and states
	typedef enum logic [1:0]
	{
		ECLK_EXTERNAL = 2'h0,
		ECLK_CPU_DIV4 = 2'h1,
		ECLK_CPU_DIV6 = 2'h2
	} eclk_src_t;

	typedef enum logic [1:0]
	{
		ST_RUN,
		ST_ASSERT_WAIT,
		ST_HELD,
		ST_RELEASE_WAIT
	} seq_state_t;

endpackage

// [design/dsp_rst_reg_if.sv]
// Carrier between the register slave and the sequencer core
`timescale 1ns/1ps
interface dsp_rst_reg_if;
	import dsp_rst_pkg::*;

	logic [1:0] clk_sel;
	logic [31:0] status;
	logic [STRAP_W-1:0] straps;

	modport regs
	(
		output clk_sel,
		input status,
		input straps
	);

	modport seq
	(
		input clk_sel,
		output status,
		output straps
	);
endinterface

// [design/dsp_rst_regs.sv]
// AHB-Lite register slave for the reset sequencer
`timescale 1ns/1ps
module dsp_rst_regs
	import dsp_rst_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Register carrier
	dsp_rst_reg_if.regs rif
);

	// ==========================================================
	// Decode
	logic [1:0] ctrl_r;
	logic wr_pend_r;
	logic [31:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic hresp_r;

	wire acc = i_hsel & i_htrans[1] & i_hready;
	wire word_ok = (i_hsize == 3'h2) & (i_haddr[1:0] == 2'h0);
	wire wr_take = acc & i_hwrite & word_ok;
	wire rd_take = acc & ~i_hwrite;
	wire ctrl_wr_now = wr_pend_r & (wr_addr_r == CTRL_OFF);
	// Forward a write in its data phase so a back-to-back read sees it
	wire [1:0] ctrl_cur = ctrl_wr_now ? i_hwdata[1:0] : ctrl_r;
	wire [31:0] rd_mux = ~word_ok ? 32'h0000_0000 :
		(i_haddr == CTRL_OFF) ? {30'h0000_0000, ctrl_cur} :
		(i_haddr == STATUS_OFF) ? rif.status :
		(i_haddr == STRAPS_OFF) ? {{(32-STRAP_W){1'b0}}, rif.straps} :
		32'h0000_0000;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ctrl_r <= CTRL_RST;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h0000_0000;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_cur;
			if (i_hready)
			begin
				wr_pend_r <= wr_take;
				wr_addr_r <= i_haddr;
			end
			if (rd_take)
				hrdata_r <= rd_mux;
		end
	end

	assign o_hrdata = hrdata_r;
	assign o_hreadyout = hreadyout_r;
	assign o_hresp = hresp_r;
	assign rif.clk_sel = ctrl_r;

endmodule

// [design/dsp_reset_boot_sequence.sv]
// Device reset sequencer: pin-group release, memory clock resync, strap capture
// How it works
// RULE1: Board holds reset 250 us in multiplied modes.
// RULE2: Reset pulse lasts 250 us even when stable.
// RULE3: Reset never re-locks PLL; hold core meanwhile.
// RULE4: Straps valid four slow periods before release.
// RULE5: Straps stay stable four CPU periods after release.
// RULE6: Straps taken from secondary address lines 20:13,11,9:7.
// RULE7: Host data line five is a strap.
// RULE8: PCI clock runs 32 periods before release.
// RULE9: Memory clock synchronised between 2E and 3P+20E.
// RULE10: Memory clock resynchronised within 16070P after release.
// RULE11: Memory clock out floats after 2E, returns 16070P.
// RULE12: Memory bus floats between 2E and 3P+4E.
// RULE13: Memory bus valid between 16E and 16070P.
// RULE14: Bus request, hold acknowledge follow same windows.
// RULE15: General pins float at once, valid 2P..16070P.
// RULE16: EEPROM pins held low only when PCI, no port2.
// RULE17: PCI enable strap fixed and always valid.
// RULE18: Port2 enable strap valid, may change live.
// RULE19: NMI low and high at least 4P.
// RULE20: External interrupts low and high at least 8P.
// RULE21: Straps latched at release, held until next reset.
// RULE22: E is external clock, CPU/4 or CPU/6.
`timescale 1ns/1ps
module dsp_reset_boot_sequence
	import dsp_rst_pkg::*;
#(
	parameter int REL_MAX_CYC = RELEASE_MAX_CYC
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Board pins
	input wire logic i_dev_reset_b,
	input wire logic i_pll_locked,
	input wire logic i_memif_input_clock,
	input wire logic [20:7] i_secondary_memif_address_lines,
	input wire logic i_host_data_line_five,
	input wire logic i_pci_enable_strap,
	input wire logic i_serial_port2_enable_strap,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Pin-group controls, enables active low while driving
	output logic o_memif_clock_out_first_oe_b,
	output logic o_memif_z_oe_b,
	output logic o_memif_high_reset,
	output logic o_general_oe_b,
	output logic o_eeprom_oe_b,
	output logic o_eeprom_hold_reset,
	// Core side
	output logic o_core_reset_b,
	output logic o_memif_clk_synced,
	output logic [STRAP_W-1:0] o_boot_straps
);

	// ==========================================================
	// Elaboration checks
	localparam int REL_LIMIT = REL_MAX_CYC - SYNC_STAGES - 2;

	generate
		if (REL_MAX_CYC < 64 || REL_MAX_CYC > 65535)
		begin : g_bad_limit
			$error("REL_MAX_CYC outside the 16-bit release counter");
		end
	endgenerate

	// ==========================================================
	// Pin synchronisers
	localparam int NSYNC = 18;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;

	assign pin_raw =
	{
		i_pll_locked,
		i_serial_port2_enable_strap,
		i_pci_enable_strap,
		i_memif_input_clock,
		i_dev_reset_b,
		i_secondary_memif_address_lines[20:13],
		i_secondary_memif_address_lines[11],
		i_secondary_memif_address_lines[9:7],
		i_host_data_line_five
	};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge i_ref_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
				begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end
				else
				begin
					sync1_r[gi] <= pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	wire [STRAP_W-1:0] strap_s = sync2_r[STRAP_W-1:0]; // RULE6 RULE7
	wire rst_low = ~sync2_r[13];
	wire eclk_s = sync2_r[14];
	wire pci_s = sync2_r[15];
	wire sp2_s = sync2_r[16];
	wire pll_s = sync2_r[17];

	// ==========================================================
	// Memory-interface clock tick (E)
	logic eclk_d_r;
	logic [2:0] div_cnt_r;

	wire [1:0] clk_sel;
	wire sel_div4 = (clk_sel == ECLK_CPU_DIV4);
	wire sel_div6 = (clk_sel == ECLK_CPU_DIV6);
	wire ext_edge = eclk_s & ~eclk_d_r;
	wire [2:0] div_top = sel_div6 ? 3'(CPU_DIV_SIX - 1) : 3'(CPU_DIV_FOUR - 1);
	wire [2:0] div_cnt_nxt = (div_cnt_r >= div_top) ? 3'h0 : div_cnt_r + 3'h1;
	// Unused code 3 falls back to the external clock
	wire e_tick = (sel_div4 | sel_div6) ? (div_cnt_r == 3'h0) : ext_edge; // RULE22

	// ==========================================================
	// Sequencer
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [4:0] ecnt_r;
	logic [15:0] pcnt_r;

	// PLL lock is only watched; reset never touches the PLL
	wire pll_ok = pll_s;
	// First tick after a state change may be a partial period, so one extra is counted
	wire e_done = e_tick & (ecnt_r == 5'(ASSERT_MIN_E));
	wire rel_min_met = (ecnt_r > 5'(RELEASE_MIN_E)) & (pcnt_r >= 16'(RELEASE_MIN_CYC - 1));
	wire rel_max_hit = (pcnt_r == 16'(REL_LIMIT));
	wire release_done = rel_min_met | rel_max_hit; // RULE10 RULE13

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN:
			begin
				if (rst_low | ~pll_ok)
					state_nxt = ST_ASSERT_WAIT;
			end
			ST_ASSERT_WAIT:
			begin
				if (e_done)
					state_nxt = ST_HELD; // RULE9 RULE12
			end
			ST_HELD:
			begin
				if (~rst_low & pll_ok)
					state_nxt = ST_RELEASE_WAIT; // RULE3
			end
			ST_RELEASE_WAIT:
			begin
				if (rst_low | ~pll_ok)
					state_nxt = ST_HELD;
				else if (release_done)
					state_nxt = ST_RUN;
			end
		endcase
	end

	wire state_chg = (state_nxt != state_r);
	wire [4:0] ecnt_nxt = state_chg ? 5'h00 :
		(e_tick & (ecnt_r != 5'h1f)) ? ecnt_r + 5'h01 : ecnt_r;
	wire [15:0] pcnt_nxt = (state_chg | (state_r != ST_RELEASE_WAIT)) ? 16'h0000 :
		pcnt_r + 16'h0001;
	wire strap_take = (state_r == ST_HELD) & (state_nxt == ST_RELEASE_WAIT);

	// ==========================================================
	// Pin-group next values
	wire eeprom_mode = pci_s & ~sp2_s;
	wire general_float_nxt = (state_nxt != ST_RUN); // RULE15
	wire memif_float_nxt = (state_nxt == ST_HELD) | (state_nxt == ST_RELEASE_WAIT); // RULE12
	wire synced_nxt = (state_nxt == ST_RUN) | (state_nxt == ST_HELD); // RULE9 RULE10
	wire eeprom_hold_nxt = eeprom_mode & general_float_nxt; // RULE16
	wire eeprom_float_nxt = general_float_nxt & ~eeprom_mode; // RULE16

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			eclk_d_r <= 1'b0;
			div_cnt_r <= 3'h0;
			state_r <= ST_HELD;
			ecnt_r <= 5'h00;
			pcnt_r <= 16'h0000;
		end
		else
		begin
			eclk_d_r <= eclk_s;
			div_cnt_r <= div_cnt_nxt;
			state_r <= state_nxt;
			ecnt_r <= ecnt_nxt;
			pcnt_r <= pcnt_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_memif_clock_out_first_oe_b <= 1'b1;
			o_memif_z_oe_b <= 1'b1;
			o_memif_high_reset <= 1'b1;
			o_general_oe_b <= 1'b1;
			o_eeprom_oe_b <= 1'b1;
			o_eeprom_hold_reset <= 1'b0;
			o_core_reset_b <= 1'b0;
			o_memif_clk_synced <= 1'b0;
		end
		else
		begin
			o_memif_clock_out_first_oe_b <= memif_float_nxt; // RULE11
			o_memif_z_oe_b <= memif_float_nxt; // RULE12 RULE13
			o_memif_high_reset <= memif_float_nxt; // RULE14
			o_general_oe_b <= general_float_nxt; // RULE15
			o_eeprom_oe_b <= eeprom_float_nxt; // RULE16
			o_eeprom_hold_reset <= eeprom_hold_nxt; // RULE16
			o_core_reset_b <= (state_nxt == ST_RUN); // RULE3
			o_memif_clk_synced <= synced_nxt;
		end
	end

	// Straps sampled at release, then frozen for the whole run
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_boot_straps <= '0;
		else if (strap_take)
			o_boot_straps <= strap_s; // RULE21
	end

	// ==========================================================
	// Registers
	dsp_rst_reg_if rif ();

	assign clk_sel = rif.clk_sel;
	assign rif.straps = o_boot_straps;
	assign rif.status =
	{
		26'h000_0000,
		pll_ok,
		eeprom_mode,
		o_core_reset_b,
		o_memif_clk_synced,
		state_r
	};

	dsp_rst_regs u_regs
	(
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hsize(i_hsize),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.o_hrdata(o_hrdata),
		.o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp),
		.rif(rif.regs)
	);

	// ==========================================================
	// Checks
	strap_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE21
		(state_r != ST_HELD) && ($past(state_r) != ST_HELD) |-> $stable(o_boot_straps))
		else $error("straps changed outside release");

	strap_take_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE6
		strap_take |=> o_boot_straps[STRAP_W-1:1] == $past(strap_s[STRAP_W-1:1]))
		else $error("address straps not captured at release");

	host_strap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE7
		strap_take |=> o_boot_straps[STRAP_HOST_D5_BIT] == $past(strap_s[STRAP_HOST_D5_BIT]))
		else $error("host data strap not captured");

	bus_float_min_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE12
		$rose(o_memif_z_oe_b) |-> $past(state_r) == ST_ASSERT_WAIT && $past(e_done))
		else $error("memory bus floated before two E periods");

	bus_valid_min_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE13
		$fell(o_memif_z_oe_b) |-> $past(ecnt_r) >= 5'(RELEASE_MIN_E) || $past(rel_max_hit))
		else $error("memory bus driven before sixteen E periods");

	release_max_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE10
		(state_r == ST_RELEASE_WAIT) && rel_max_hit && !rst_low && pll_ok
		|=> !o_memif_clock_out_first_oe_b && o_memif_clk_synced)
		else $error("release limit passed without driving clock out");

	general_float_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE15
		(state_r == ST_RUN) && rst_low |=> o_general_oe_b && !o_core_reset_b)
		else $error("general pins not floated on reset");

	general_min_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE15
		$fell(o_general_oe_b) |-> $past(pcnt_r) >= 16'(RELEASE_MIN_CYC - 1))
		else $error("general pins driven before two CPU periods");

	eeprom_group_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE16
		!$past(eeprom_mode) |-> (o_eeprom_oe_b == o_general_oe_b) && !o_eeprom_hold_reset)
		else $error("eeprom pins left the general group");

	pll_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE3
		(state_r == ST_HELD) && !pll_ok |=> (state_r == ST_HELD) && !o_core_reset_b)
		else $error("released while PLL unlocked");

	sync_window_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE9
		$rose(state_r == ST_ASSERT_WAIT) && (sel_div4 || sel_div6) && !$changed(clk_sel)
		|-> ##[1:30] o_memif_clk_synced)
		else $error("memory clock not resynchronised in time");

	div_four_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE22
		sel_div4 && $stable(clk_sel) && e_tick && (div_cnt_r == 3'h0) |=> !e_tick[*3])
		else $error("CPU/4 tick spacing wrong");

endmodule

// [testbench/board_ctrl_model.sv]
// Board reset controller model: reset pin, PLL lock, memory input clock and straps
`timescale 1ns/1ps
module board_ctrl_model
#(
	parameter int RST_MIN_CYC = 50000
)
(
	// Clock
	input wire logic i_ref_clk,
	// Board pins
	output logic o_dev_reset_b,
	output logic o_pll_locked,
	output logic o_memif_input_clock,
	output logic [20:7] o_secondary_memif_address_lines,
	output logic o_host_data_line_five,
	output logic o_pci_enable_strap,
	output logic o_serial_port2_enable_strap
);
	logic pci_clock;
	logic nmi_b;
	logic ext_irq_b;

	// PCI clock runs free from time zero, about 24 periods before the first release and far more before later ones
	initial
	begin
		pci_clock = 1'b0;
		nmi_b = 1'b1;
		ext_irq_b = 1'b1;
		forever #15 pci_clock = ~pci_clock;
	end

	// Interrupt pulses keep their minimum low and high widths
	task irq_pulse();
		@(posedge i_ref_clk);
		nmi_b <= 1'b0;
		ext_irq_b <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		nmi_b <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		ext_irq_b <= 1'b1;
		repeat (8) @(posedge i_ref_clk);
	endtask

	// Memory input clock runs free at 40 ns, phase unrelated to the CPU clock
	initial
	begin
		o_dev_reset_b = 1'b1;
		o_pll_locked = 1'b1;
		o_memif_input_clock = 1'b0;
		o_secondary_memif_address_lines = 14'h0000;
		o_host_data_line_five = 1'b0;
		o_pci_enable_strap = 1'b0;
		o_serial_port2_enable_strap = 1'b0;
		#1.3;
		forever #20 o_memif_input_clock = ~o_memif_input_clock;
	end

	task enter_reset(input logic pci, input logic sp2);
		@(posedge i_ref_clk);
		o_dev_reset_b <= 1'b0;
		o_pci_enable_strap <= pci;
		o_serial_port2_enable_strap <= sp2;
	endtask

	// Straps settle a whole pulse width ahead of release
	task leave_reset(input logic [20:7] lines, input logic hd5);
		@(posedge i_ref_clk);
		o_secondary_memif_address_lines <= lines;
		o_host_data_line_five <= hd5;
		repeat (RST_MIN_CYC) @(posedge i_ref_clk);
		o_dev_reset_b <= 1'b1;
	endtask

	task set_pll(input logic locked);
		@(posedge i_ref_clk);
		o_pll_locked <= locked;
	endtask

	// Changes come only after the hold window has passed
	task drift_straps();
		repeat (4) @(posedge i_ref_clk);
		o_secondary_memif_address_lines <= ~o_secondary_memif_address_lines;
		o_host_data_line_five <= ~o_host_data_line_five;
	endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the device reset sequencer
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			miscompares++; \
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end
module testbench;
	import dsp_rst_pkg::*;
	localparam int REL_CYC = 400;
	localparam int ECLK_CYC = 8;
	logic i_ref_clk, i_rst_b, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, mode;
	logic [2:0] hsize;
	logic dev_rst_b, pll, eclk, hd5, pci, sp2, hd5_v;
	logic [20:7] lines, lines_v;
	logic clk_oe_b, z_oe_b, high_rst, gen_oe_b, ee_oe_b, ee_hold, core_rst_b, synced;
	logic [STRAP_W-1:0] straps, exp_s;
	int miscompares, samples_checked, c, e;

	board_ctrl_model #(.RST_MIN_CYC(60)) board_ctrl_model_inst (.i_ref_clk(i_ref_clk),
		.o_dev_reset_b(dev_rst_b), .o_pll_locked(pll), .o_memif_input_clock(eclk),
		.o_secondary_memif_address_lines(lines), .o_host_data_line_five(hd5),
		.o_pci_enable_strap(pci), .o_serial_port2_enable_strap(sp2));

	dsp_reset_boot_sequence #(.REL_MAX_CYC(REL_CYC)) dsp_reset_boot_sequence_inst (
		.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_dev_reset_b(dev_rst_b),
		.i_pll_locked(pll), .i_memif_input_clock(eclk),
		.i_secondary_memif_address_lines(lines), .i_host_data_line_five(hd5),
		.i_pci_enable_strap(pci), .i_serial_port2_enable_strap(sp2), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_memif_clock_out_first_oe_b(clk_oe_b),
		.o_memif_z_oe_b(z_oe_b), .o_memif_high_reset(high_rst), .o_general_oe_b(gen_oe_b),
		.o_eeprom_oe_b(ee_oe_b), .o_eeprom_hold_reset(ee_hold), .o_core_reset_b(core_rst_b),
		.o_memif_clk_synced(synced), .o_boot_straps(straps));

	initial
	begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	function automatic logic [STRAP_W-1:0] strap_map(input logic [20:7] l, input logic h);
		return {l[20:13], l[11], l[9:7], h};
	endfunction

	task end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Counts edges into c; a missed bound ends the run
	task automatic wait_sig(ref logic s, input logic v, input int lim);
		do
		begin
			@(posedge i_ref_clk);
			#1;
			c++;
		end
		while (s !== v && c < lim);
		if (s !== v)
		begin
			miscompares++;
			end_of_test();
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			miscompares++;
			end_of_test();
		end
	endtask

	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
		@(posedge i_ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	initial
	begin
		repeat (100000) @(posedge i_ref_clk);
		miscompares++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(49710));
		{i_rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		miscompares = 0;
		samples_checked = 0;
		repeat (5) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		ahb(1'b0, CTRL_OFF, 32'h0000_0000, 3'h2);
		`CHK(rd, 32'h0000_0000);
		ahb(1'b0, 32'h0000_0010, 32'h0000_0000, 3'h2);
		`CHK(rd, 32'h0000_0000);
		// Byte-sized write must be ignored
		ahb(1'b1, CTRL_OFF, 32'h0000_0002, 3'h0);
		ahb(1'b0, CTRL_OFF, 32'h0000_0000, 3'h2);
		`CHK(rd, 32'h0000_0000);
		c = 0;
		wait_sig(core_rst_b, 1'b1, REL_CYC + 10);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			mode = 2'(i % 3);
			e = (mode == 2'h1) ? CPU_DIV_FOUR : (mode == 2'h2) ? CPU_DIV_SIX : ECLK_CYC;
			ahb(1'b1, CTRL_OFF, {30'h0000_0000, mode}, 3'h2);
			ahb(1'b0, CTRL_OFF, 32'h0000_0000, 3'h2);
			`CHK(rd[1:0], mode);
			board_ctrl_model_inst.enter_reset(i[1], i[0]);
			c = 0;
			wait_sig(gen_oe_b, 1'b1, 10);
			`CHK(c, 3);
			`CHK(ee_oe_b, ~(pci & ~sp2));
			`CHK(ee_hold, pci & ~sp2);
			wait_sig(z_oe_b, 1'b1, 200);
			`CHK(c >= 2 * e && c <= 3 + 4 * e, 1'b1);
			`CHK({clk_oe_b, high_rst, synced}, 3'h7);
			board_ctrl_model_inst.set_pll(1'b0);
			lines_v = 14'($urandom);
			hd5_v = 1'($urandom);
			board_ctrl_model_inst.leave_reset(lines_v, hd5_v);
			repeat (20) @(posedge i_ref_clk);
			#1;
			`CHK({core_rst_b, z_oe_b}, 2'h1);
			board_ctrl_model_inst.set_pll(1'b1);
			c = 0;
			wait_sig(z_oe_b, 1'b0, REL_CYC + 10);
			`CHK(c >= 16 * e && c <= REL_CYC, 1'b1);
			`CHK({gen_oe_b, clk_oe_b, high_rst, ee_hold}, 4'h0);
			`CHK({synced, core_rst_b}, 2'h3);
			exp_s = strap_map(lines_v, hd5_v);
			`CHK(straps, exp_s);
			board_ctrl_model_inst.drift_straps();
			board_ctrl_model_inst.irq_pulse();
			repeat (10) @(posedge i_ref_clk);
			`CHK(straps, exp_s);
			ahb(1'b0, STRAPS_OFF, 32'h0000_0000, 3'h2);
			`CHK(rd[STRAP_W-1:0], exp_s);
			ahb(1'b0, STATUS_OFF, 32'h0000_0000, 3'h2);
			`CHK(rd[5:0], {1'b1, pci & ~sp2, 4'hC});
			$display("test reset cycle %0d done", i);
		end
		end_of_test();
	end
endmodule
